// ===== hw/lsd_pkg.sv
// Package for the sync delay and second-link test size configuration block
package lsd_pkg;
  // Printed offsets are not all multiples of four: they are indices, byte address = index * 4
  localparam logic [7:0]  IDX_VSIZE_LSB = 8'h26;
  localparam logic [7:0]  IDX_VSIZE_MSB = 8'h27;
  localparam logic [7:0]  IDX_LAG_LSB   = 8'h28;
  localparam logic [7:0]  IDX_LAG_MSB   = 8'h29;
  localparam logic [7:0]  IDX_MODE      = 8'h30;       // Own register: mode bits
  localparam logic [7:0]  IDX_STATUS    = 8'h31;       // Own register: delay status
  localparam int          ADDR_W        = 12;
  localparam int          IDX_LSB       = 2;           // Byte address to index shift
  // Field layout
  localparam int          LSB_W         = 8;
  localparam int          MSB_W         = 4;
  localparam int          CNT_W         = 12;
  localparam logic [7:0]  LSB_RST       = 8'h00;
  localparam logic [3:0]  MSB_RST       = 4'h0;
  localparam int          MODE_SINGLE_BIT = 0;        // Mode reg bit: single output mode
  localparam int          MODE_CHCFG_LO   = 1;        // Mode reg bits 2:1: DSI channel configuration
  localparam logic [1:0]  CHCFG_DUAL_OE   = 2'h0;
  localparam logic [1:0]  CHCFG_DUAL_LR   = 2'h1;
  localparam logic [1:0]  CHCFG_TWO_STREAM = 2'h2;
  localparam int          MIN_LAG         = 32;       // Least legal programmed delay
  localparam int          PIPE_LAT        = 10;       // Inherent extra latency in pixel clocks
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Sync event carrier
  typedef struct packed {
    logic hsync;
    logic vsync;
  } lsd_sync_t;
  // Delay engine state
  typedef enum logic [1:0] {LSD_IDLE, LSD_COUNT, LSD_FIRE} lsd_state_t;
endpackage

// ===== hw/lsd_sync_delay_cfg.sv
// Sync delay engine and register slave for the first-link sync lag and second-link test size
`timescale 1ns/10ps
// What this block does
// - Test lines: 12 bits from two registers
// - Test lines feed test pattern only
// - Test lines used only in two-stream configuration
// - Delay each received sync by programmed clocks; syncs during a count merge, syncs in the release clock are lost
// - Delay applies single mode or dual 00/01
// - Delay adds to roughly ten pipeline clocks
// - Delay: 12 bits, low and high registers
// - All fields reset zero, read and write
// - Configuration 10 means two independent streams
module lsd_sync_delay_cfg
  import lsd_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Sync events from the DSI receive path
  input  wire lsd_pkg::lsd_sync_t      dsi_sync,
  // Delayed syncs to the two LVDS links
  output lsd_pkg::lsd_sync_t           first_link_sync,
  output lsd_pkg::lsd_sync_t           second_link_sync,
  // Test pattern line count for the second link, zero when not applicable
  output logic [CNT_W-1:0]             second_link_test_lines
);
  import lsd_pkg::*;

  // Register fields. The upper registers keep only four bits; the reserved
  // upper bits of those bytes are dropped on write and read back as zero.
  logic [LSB_W-1:0]  second_link_test_lines_lsb_q;
  logic [MSB_W-1:0]  second_link_test_lines_msb_q;
  logic [LSB_W-1:0]  first_link_sync_lag_lsb_q;
  logic [MSB_W-1:0]  first_link_sync_lag_msb_q;
  logic              single_out_q;       // 1 = single LVDS output
  logic [1:0]        chan_cfg_q;         // DSI channel configuration

  // Bus handshake state
  // Address and data may arrive in either order, so each is parked until both are in
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  // Input synchronisers: the syncs arrive from another clock domain
  lsd_sync_t         sync_s1_q;
  lsd_sync_t         sync_s2_q;
  lsd_sync_t         sync_s3_q;

  // Delay engine: one counter serves both sync kinds, so events that fall
  // inside one counting window leave together
  lsd_state_t        state_q;            // Idle, counting or releasing
  logic [CNT_W-1:0]  cnt_q;              // Clocks counted since detection
  lsd_sync_t         pend_q;             // Events waiting for release
  lsd_sync_t         out_pipe_q [PIPE_LAT]; // Released events pass the fixed pipe

  // Decoded views of the registers and the bus
  logic [CNT_W-1:0]  lag;                // Programmed first-link lag
  logic              lag_active;         // Engine runs in this configuration
  lsd_sync_t         sync_rise;          // One-clock event per sync kind
  logic [7:0]        widx;               // Index of the parked write
  logic [7:0]        ridx;               // Index of the offered read
  logic              w_go;               // Write completes this clock

  // The host owns the lower limit on the lag; smaller values are taken as
  // given, and the engine still ends every count that it starts
  assign lag = {first_link_sync_lag_msb_q, first_link_sync_lag_lsb_q};
  // Delay engine runs in single mode, or dual mode with channel cfg 00/01
  assign lag_active = single_out_q ||
                      (chan_cfg_q == CHCFG_DUAL_OE) || (chan_cfg_q == CHCFG_DUAL_LR);
  // A rising edge of each synchronised sync line marks one event
  assign sync_rise.hsync = sync_s2_q.hsync & ~sync_s3_q.hsync;
  assign sync_rise.vsync = sync_s2_q.vsync & ~sync_s3_q.vsync;
  // The register index sits above the two byte-offset bits of the address
  assign widx = awaddr_q[IDX_LSB +: 8];
  assign ridx = s_axi_araddr[IDX_LSB +: 8];
  // A write completes once both halves are parked and the last answer is gone
  assign w_go = aw_held_q && w_held_q && !s_axi_bvalid;

  // Two-flop synchroniser plus one edge stage that reads only the second flop
  // The first flop may settle late; nothing but the second flop reads it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync_s1_q <= '0;
      sync_s2_q <= '0;
      sync_s3_q <= '0;
    end else begin
      sync_s1_q <= dsi_sync;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end

  // Write address and data are taken independently, in either order
  // Each half is parked in its own holding register until the write completes,
  // so a master may offer either one first
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // Ready pulses for one cycle when a new item can be held
      s_axi_awready <= !aw_held_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready  <= !w_held_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (w_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (w_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries field data
  // A write with lane 0 disabled is answered but changes nothing;
  // reserved upper bits of the size and lag bytes are simply dropped
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      second_link_test_lines_lsb_q <= LSB_RST;
      second_link_test_lines_msb_q <= MSB_RST;
      first_link_sync_lag_lsb_q    <= LSB_RST;
      first_link_sync_lag_msb_q    <= MSB_RST;
      single_out_q                 <= 1'b0;
      chan_cfg_q                   <= CHCFG_DUAL_OE;
    end else if (w_go && wstrb_q[0]) begin
      case (widx)
        IDX_VSIZE_LSB: second_link_test_lines_lsb_q <= wdata_q[LSB_W-1:0];
        IDX_VSIZE_MSB: second_link_test_lines_msb_q <= wdata_q[MSB_W-1:0];
        IDX_LAG_LSB:   first_link_sync_lag_lsb_q    <= wdata_q[LSB_W-1:0];
        IDX_LAG_MSB:   first_link_sync_lag_msb_q    <= wdata_q[MSB_W-1:0];
        IDX_MODE: begin
          single_out_q <= wdata_q[MODE_SINGLE_BIT];
          chan_cfg_q   <= wdata_q[MODE_CHCFG_LO +: 2];
        end
        default: ;                                                               // Unmapped: ignored
      endcase
    end
  end

  // Write response; unmapped index answers SLVERR
  // The answer stands until the master takes it, and no new write completes
  // before then, so one write at most is under way
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (w_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (widx == IDX_VSIZE_LSB || widx == IDX_VSIZE_MSB || widx == IDX_LAG_LSB ||
                       widx == IDX_LAG_MSB || widx == IDX_MODE || widx == IDX_STATUS) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one read at a time, answer two cycles after arvalid
  // The status word is a live debug view of the engine; it is not held
  // still, so two reads of it may differ
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (ridx)
          IDX_VSIZE_LSB: s_axi_rdata <= {24'h000000, second_link_test_lines_lsb_q};
          IDX_VSIZE_MSB: s_axi_rdata <= {28'h0000000, second_link_test_lines_msb_q};
          IDX_LAG_LSB:   s_axi_rdata <= {24'h000000, first_link_sync_lag_lsb_q};
          IDX_LAG_MSB:   s_axi_rdata <= {28'h0000000, first_link_sync_lag_msb_q};
          IDX_MODE:      s_axi_rdata <= {29'h0000000, chan_cfg_q, single_out_q};
          IDX_STATUS:    s_axi_rdata <= {16'h0000, cnt_q, 2'h0, pend_q};              // Live engine state
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Delay counter: starts on detected sync, releases when the count is reached.
  // Limitation: a sync arriving while counting is merged into the pending one;
  // a lag below the legal minimum can therefore lose spacing between events.
  // A lag of zero or one still counts one clock, so no event ever passes
  // straight from the synchroniser to the links; the fixed pipe behind the
  // counter adds the inherent latency on top.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= LSD_IDLE;
      cnt_q   <= '0;
      pend_q  <= '0;
    end else begin
      case (state_q)
        LSD_IDLE: begin
          if (lag_active && (sync_rise.hsync || sync_rise.vsync)) begin
            pend_q  <= sync_rise;
            cnt_q   <= 12'h001;
            state_q <= (lag <= 12'h001) ? LSD_FIRE : LSD_COUNT;
          end
        end
        LSD_COUNT: begin
          pend_q <= pend_q | sync_rise;
          cnt_q  <= cnt_q + 12'h001;
          if (cnt_q + 12'h001 >= lag) begin
            state_q <= LSD_FIRE;
          end
        end
        LSD_FIRE: begin
          pend_q  <= '0;
          cnt_q   <= '0;
          state_q <= LSD_IDLE;
        end
        default: state_q <= LSD_IDLE;
      endcase
    end
  end

  // Fixed pipeline stages that model the inherent latency added after the lag.
  // The head stage loads from the engine and every later stage copies the one
  // before it; splitting the two keeps the index of the copy in range.
  generate
    for (genvar i = 0; i < PIPE_LAT; i++) begin : g_pipe
      if (i == 0) begin : g_head
        // Head stage: a released event enters for exactly one clock
        always_ff @(posedge core_clk) begin
          if (!reset_n) begin
            out_pipe_q[i] <= '0;
          end else begin
            out_pipe_q[i] <= (state_q == LSD_FIRE) ? pend_q : '0;
          end
        end
      end else begin : g_tail
        // Later stages: plain shift, one clock each
        always_ff @(posedge core_clk) begin
          if (!reset_n) begin
            out_pipe_q[i] <= '0;
          end else begin
            out_pipe_q[i] <= out_pipe_q[i-1];
          end
        end
      end
    end
  endgenerate

  // Output drivers: single mode feeds the first link only, dual 00/01 feeds both
  // Every output is a flop here, so the links see clean one-clock pulses and
  // the test generator sees a steady line count
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      first_link_sync        <= '0;
      second_link_sync       <= '0;
      second_link_test_lines <= '0;
    end else begin
      first_link_sync  <= out_pipe_q[PIPE_LAT-1];
      second_link_sync <= single_out_q ? lsd_sync_t'('0) : out_pipe_q[PIPE_LAT-1];
      // Size goes to the test generator only, and only in two-stream mode
      second_link_test_lines <= (chan_cfg_q == CHCFG_TWO_STREAM) ?
        {second_link_test_lines_msb_q, second_link_test_lines_lsb_q} : '0;
    end
  end

endmodule

// ===== tb/lsd_chk.sv
// Concurrent checks on the ports of the sync delay and test size block
`timescale 1ns/10ps
module lsd_chk
  import lsd_pkg::*;
(
  input wire logic                      core_clk,
  input wire logic                      reset_n,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [31:0]               s_axi_rdata,
  input wire lsd_pkg::lsd_sync_t        first_link_sync,
  input wire lsd_pkg::lsd_sync_t        second_link_sync,
  input wire logic [lsd_pkg::CNT_W-1:0] second_link_test_lines
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Both write channels taken at one edge
  sequence s_wtake;
    s_axi_awready && s_axi_wready;
  endsequence
  property p_wresp; s_wtake |-> ##2 s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("late write answer");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer stuck");
  property p_rresp; s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("late read answer");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  // Test line count moves only as a write completes
  property p_lines; $changed(second_link_test_lines) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_lines: assert property (p_lines) else $error("line count moved alone");
  property p_rst; !$past(reset_n) |-> !s_axi_bvalid && !s_axi_rvalid && second_link_test_lines == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_pulse; first_link_sync != '0 |=> first_link_sync == '0; endproperty
  a_pulse: assert property (p_pulse) else $error("sync pulse too long");
  property p_pair; second_link_sync != '0 |-> second_link_sync == first_link_sync; endproperty
  a_pair: assert property (p_pair) else $error("second link sync alone");
endmodule

bind lsd_sync_delay_cfg lsd_chk i_chk (.core_clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .first_link_sync, .second_link_sync, .second_link_test_lines);

// ===== tb/lsd_sync_src.sv
// Model of the receive path that hands sync events to the block
`timescale 1ns/10ps
module lsd_sync_src
  import lsd_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          go,
  input  wire logic          sel,
  output lsd_pkg::lsd_sync_t dsi_sync
);
  logic [2:0] len_q = 3'h0; // Cycles left high; long enough for the two sync flops
  logic       sel_q = 1'h0; // High picks vsync, low hsync
  // A request starts one four-cycle pulse; lines idle low between events
  always_ff @(posedge core_clk) begin
    if (go) begin
      len_q <= 3'h4;
      sel_q <= sel;
    end else if (len_q != 3'h0) begin
      len_q <= len_q - 3'h1;
    end
  end
  assign dsi_sync = (len_q == 3'h0) ? 2'h0 : (sel_q ? 2'h1 : 2'h2);
endmodule

// ===== tb/lsd_sync_delay_cfg_bench.sv
// Self-checking bench for the sync delay and test size block
`timescale 1ns/10ps
module lsd_sync_delay_cfg_bench;
  import lsd_pkg::*;
  localparam logic [11:0] LAG = 12'h121; // Above the host minimum, upper field non-zero
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, go = 1'h0, sel = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [CNT_W-1:0] lines;
  lsd_sync_t dsi_sync, first_sync, second_sync;
  int errors = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  lsd_sync_src i_src (.core_clk(core_clk), .go(go), .sel(sel), .dsi_sync(dsi_sync));
  lsd_sync_delay_cfg i_dut (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dsi_sync(dsi_sync), .first_link_sync(first_sync), .second_link_sync(second_sync),
    .second_link_test_lines(lines));
  task automatic results();
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Write one word; address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i <= 60; i++) begin
      @(posedge core_clk);
      if (i == 60) begin
        errors++;
        results();
      end
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    chk($sformatf("bresp %h", idx), er, bresp);
    bready <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i <= 60; i++) begin
      @(posedge core_clk);
      if (i == 60) begin
        errors++;
        results();
      end
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    chk($sformatf("rdata %h", idx), ed, rdata);
    chk($sformatf("rresp %h", idx), er, rresp);
    rready <= 1'h0;
    @(posedge core_clk);
  endtask
  // Reset values, upper field masking, unmapped place refused
  task automatic t_regs();
    for (int i = 0; i < 4; i++) rd(IDX_VSIZE_LSB + 8'(i), 32'h0, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_VSIZE_MSB, 8'hff, RESP_OKAY);
    rd(IDX_VSIZE_MSB, 32'h0f, RESP_OKAY);
    wr(IDX_LAG_MSB, 8'hf7, RESP_OKAY);
    rd(IDX_LAG_MSB, 32'h07, RESP_OKAY);
    wr(8'h2a, 8'h55, RESP_SLVERR);
    rd(8'h2a, 32'h0, RESP_SLVERR);
  endtask
  // Test line count shows only in the two-stream configuration
  task automatic t_lines();
    wr(IDX_VSIZE_LSB, 8'h34, RESP_OKAY);
    wr(IDX_VSIZE_MSB, 8'h0a, RESP_OKAY);
    wr(IDX_MODE, 8'h02, RESP_OKAY);
    chk("lines cfg01", 12'h000, lines);
    wr(IDX_MODE, 8'h04, RESP_OKAY);
    rd(IDX_MODE, 32'h04, RESP_OKAY);
    chk("lines cfg10", 12'ha34, lines);
  endtask
  // One sync event; s picks vsync, ea and eb the links expected to fire
  task automatic t_sync(input logic [7:0] mode, input logic s, input logic ea, input logic eb);
    logic a;
    logic b;
    int n;
    wr(IDX_MODE, mode, RESP_OKAY);
    sel <= s;
    go <= 1'h1;
    @(posedge core_clk);
    go <= 1'h0;
    for (n = 0; n < 400; n++) begin
      @(posedge core_clk);
      a = s ? first_sync.vsync : first_sync.hsync;
      b = s ? second_sync.vsync : second_sync.hsync;
      if (a || b) break;
    end
    chk($sformatf("link a mode %h", mode), ea, a);
    chk($sformatf("link b mode %h", mode), eb, b);
    if (ea) chk("lag", 1, n >= LAG + PIPE_LAT + 3 && n <= LAG + PIPE_LAT + 9);
    repeat (20) @(posedge core_clk);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'h1;
    t_regs();
    t_lines();
    wr(IDX_LAG_LSB, LAG[7:0], RESP_OKAY);
    wr(IDX_LAG_MSB, {4'h0, LAG[11:8]}, RESP_OKAY);
    t_sync(8'h01, 1'h0, 1'h1, 1'h0);
    t_sync(8'h00, 1'h1, 1'h1, 1'h1);
    t_sync(8'h02, 1'h0, 1'h1, 1'h1);
    t_sync(8'h04, 1'h1, 1'h0, 1'h0);
    t_sync(8'h05, 1'h0, 1'h1, 1'h0);
    t_sync(8'h06, 1'h1, 1'h0, 1'h0);
    results();
  end
endmodule
